// file: hw/adc_seq_params.svh
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// register port map (word index on reg_addr)
`define CTRL_OFFSET      2'h0
`define SHADOW_OFFSET    2'h1
`define STATUS_OFFSET    2'h2

// control word reset value
`define CTRL_RESET       12'h000

// last channel and default when the mark set is empty
`define CHAN_LAST        4'hF

// wake-up time from shutdown and derived cycle count
`define CLK_PERIOD_NS    100
`define WAKE_NS          1000
`define WAKE_CYCLES      ((`WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// status word field positions
`define STAT_CONV_LSB    12
`define STAT_NEXT_LSB    8
`define STAT_STATE_LSB   6
`define STAT_POWER_BIT   5
`define STAT_WAKE_BIT    4

`endif

// file: hw/adc_seq_pkg.sv
package adc_seq_pkg;

	// control word, bit 11 down to bit 0
	typedef struct packed {
		logic       step_control_bit;
		logic [3:0] channel_address_field;
		logic       power_mode_high_bit;
		logic       power_mode_low_bit;
		logic       shadow_bit;
		logic       idle_output_hold_bit;
		logic       range_bit;
		logic       coding_bit;
		logic       single_ended_select;
	} ctrl_word_t;

	// output coding of one conversion
	typedef struct packed {
		logic range_bit;
		logic single_ended_select;
		logic coding_bit;
		logic twos_complement;
	} result_fmt_t;

	// input selection of one conversion
	typedef struct packed {
		logic [3:0] pos_input;
		logic [3:0] neg_input;
		logic       differential;
	} input_sel_t;

	typedef enum logic [1:0] {
		SEQ_DIRECT = 2'b00,
		SEQ_ARMED  = 2'b01,
		SEQ_MARKED = 2'b10,
		SEQ_COUNT  = 2'b11
	} seq_state_t;

endpackage

// file: hw/pin_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser with edge pulses on the settled level
module pin_edge_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// asynchronous pin
	input  wire logic pin_in,
	// synchronised level and edges
	output logic      level,
	output logic      fall,
	output logic      rise
);

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic last_q;
	logic last_d;

	// next values; first flop feeds only the second
	always_comb begin
		meta_d = pin_in;
		sync_d = meta_q;
		last_d = sync_q;
	end

	// pins idle high
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			last_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	assign level = sync_q;
	assign fall  = last_q & ~sync_q;
	assign rise  = ~last_q & sync_q;

endmodule // pin_edge_sync

`default_nettype wire

// file: hw/chan_pair_decode.sv
`timescale 1ns/1ps
`default_nettype none

// channel code plus mode into the input pair
module chan_pair_decode
	import adc_seq_pkg::*;
(
	// code and mode
	input  wire logic [3:0] chan,
	input  wire logic       single_ended_select,
	// selected inputs
	output input_sel_t      sel
);

	// even code pairs with the one above, odd with the one below
	always_comb begin
		sel.pos_input    = chan;
		sel.differential = ~single_ended_select;
		if (single_ended_select) begin
			sel.neg_input = chan;
		end else begin
			sel.neg_input = {chan[3:1], ~chan[0]};
		end
	end

endmodule // chan_pair_decode

`default_nettype wire

// file: hw/adc_channel_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"

module adc_channel_sequencer
	import adc_seq_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [1:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// frame pin from the host
	input  wire logic        chip_select_low,
	// conversion control
	output logic             conv_start,
	output var input_sel_t   conv_sel,
	output var result_fmt_t  conv_fmt,
	output logic             powered,
	output logic             wake_done,
	output logic             idle_output_hold,
	output seq_state_t       seq_state
);

	// frame pin synchronised
	logic cs_level;
	logic cs_fall;
	logic cs_rise;

	pin_edge_sync pin_edge_sync_inst (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin_in  (chip_select_low),
		.level   (cs_level),
		.fall    (cs_fall),
		.rise    (cs_rise)
	);

	// lowest marked channel above cur, else lowest overall, else 15
	function automatic logic [3:0] next_marked(
		input logic [15:0] marks,
		input logic [3:0]  cur,
		input logic        from_start
	);
		logic [3:0] lo_all;
		logic [3:0] lo_above;
		logic       any_all;
		logic       any_above;
		lo_all    = `CHAN_LAST;
		lo_above  = `CHAN_LAST;
		any_all   = 1'b0;
		any_above = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (marks[i]) begin
				lo_all  = 4'(i);
				any_all = 1'b1;
				if (5'(i) > {1'b0, cur}) begin
					lo_above  = 4'(i);
					any_above = 1'b1;
				end
			end
		end
		if (!any_all) begin
			next_marked = `CHAN_LAST;
		end else if (any_above && !from_start) begin
			next_marked = lo_above;
		end else begin
			next_marked = lo_all;
		end
	endfunction

	// shadow word into per-channel marks, bit 15 is input 0
	function automatic logic [15:0] shadow_to_marks(input logic [15:0] w);
		logic [15:0] m;
		m = 16'h0000;
		for (int c = 0; c < 16; c++) begin
			m[c] = w[15 - c];
		end
		shadow_to_marks = m;
	endfunction

	// bus strobes
	logic ctrl_wr;
	logic shadow_wr;
	assign ctrl_wr   = reg_wr && (reg_addr == `CTRL_OFFSET);
	assign shadow_wr = reg_wr && (reg_addr == `SHADOW_OFFSET);

	ctrl_word_t  ctrl_q;
	ctrl_word_t  ctrl_d;
	ctrl_word_t  wr_word;
	seq_state_t  state_q;
	seq_state_t  state_d;
	logic [15:0] marks_q;
	logic [15:0] marks_d;
	logic [3:0]  next_chan_q;
	logic [3:0]  next_chan_d;
	logic [3:0]  conv_chan_q;
	logic [3:0]  conv_chan_d;
	input_sel_t  sel_q;
	input_sel_t  sel_d;
	input_sel_t  sel_now;
	result_fmt_t fmt_q;
	result_fmt_t fmt_d;
	logic        start_q;
	logic        start_d;

	assign wr_word = ctrl_word_t'(reg_wdata[11:0]);

	chan_pair_decode chan_pair_decode_inst (
		.chan                (next_chan_q),
		.single_ended_select (ctrl_q.single_ended_select),
		.sel                 (sel_now)
	);

	// sequencer: advance on frame start, then apply writes
	always_comb begin
		ctrl_d      = ctrl_q;
		state_d     = state_q;
		marks_d     = marks_q;
		next_chan_d = next_chan_q;
		conv_chan_d = conv_chan_q;
		sel_d       = sel_q;
		fmt_d       = fmt_q;
		start_d     = cs_fall;

		if (cs_fall) begin
			conv_chan_d = next_chan_q;
			sel_d       = sel_now;
			fmt_d.range_bit           = ctrl_q.range_bit;
			fmt_d.single_ended_select = ctrl_q.single_ended_select;
			fmt_d.coding_bit          = ctrl_q.coding_bit;
			fmt_d.twos_complement     = ~ctrl_q.coding_bit;
			unique case (state_q)
				SEQ_DIRECT, SEQ_ARMED: begin
					next_chan_d = ctrl_q.channel_address_field;
				end
				SEQ_MARKED: begin
					next_chan_d = next_marked(marks_q, next_chan_q, 1'b0);
				end
				SEQ_COUNT: begin
					if (next_chan_q >= ctrl_q.channel_address_field) begin
						next_chan_d = 4'h0;
					end else begin
						next_chan_d = next_chan_q + 4'h1;
					end
				end
			endcase
		end

		if (ctrl_wr) begin
			if (wr_word.step_control_bit && !wr_word.shadow_bit) begin
				// sequence keeps running, address and sequencer state untouched
				ctrl_d.power_mode_high_bit  = wr_word.power_mode_high_bit;
				ctrl_d.power_mode_low_bit   = wr_word.power_mode_low_bit;
				ctrl_d.idle_output_hold_bit = wr_word.idle_output_hold_bit;
				ctrl_d.range_bit            = wr_word.range_bit;
				ctrl_d.coding_bit           = wr_word.coding_bit;
				ctrl_d.single_ended_select  = wr_word.single_ended_select;
				ctrl_d.step_control_bit     = wr_word.step_control_bit;
				ctrl_d.shadow_bit           = wr_word.shadow_bit;
			end else begin
				ctrl_d = wr_word;
				unique case ({wr_word.step_control_bit, wr_word.shadow_bit})
					2'b01: begin
						state_d     = SEQ_ARMED;
						next_chan_d = wr_word.channel_address_field;
					end
					2'b11: begin
						state_d     = SEQ_COUNT;
						next_chan_d = 4'h0;
					end
					default: begin
						state_d     = SEQ_DIRECT;
						next_chan_d = wr_word.channel_address_field;
					end
				endcase
			end
		end else if (shadow_wr && state_q == SEQ_ARMED) begin
			// any pattern accepted, gaps allowed
			marks_d     = shadow_to_marks(reg_wdata);
			state_d     = SEQ_MARKED;
			next_chan_d = next_marked(shadow_to_marks(reg_wdata), 4'h0, 1'b1);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q      <= ctrl_word_t'(`CTRL_RESET);
			state_q     <= SEQ_DIRECT;
			marks_q     <= 16'h0000;
			next_chan_q <= 4'h0;
			conv_chan_q <= 4'h0;
			sel_q       <= input_sel_t'(9'h000);
			fmt_q       <= result_fmt_t'(4'h0);
			start_q     <= 1'b0;
		end else begin
			ctrl_q      <= ctrl_d;
			state_q     <= state_d;
			marks_q     <= marks_d;
			next_chan_q <= next_chan_d;
			conv_chan_q <= conv_chan_d;
			sel_q       <= sel_d;
			fmt_q       <= fmt_d;
			start_q     <= start_d;
		end
	end

	// power state and wake-up timer
	logic       powered_q;
	logic       powered_d;
	logic [7:0] wake_cnt_q;
	logic [7:0] wake_cnt_d;
	logic       wake_done_q;
	logic       wake_done_d;
	logic       in_frame_q;
	logic       in_frame_d;

	always_comb begin
		powered_d   = powered_q;
		wake_cnt_d  = wake_cnt_q;
		wake_done_d = wake_done_q;
		in_frame_d  = in_frame_q;
		if (cs_fall) begin
			in_frame_d = 1'b1;
		end else if (cs_rise) begin
			in_frame_d = 1'b0;
		end
		if (ctrl_q.power_mode_high_bit) begin
			powered_d = 1'b1;
		end else if (cs_rise && in_frame_q) begin
			powered_d = 1'b0;
		end else if (cs_fall) begin
			powered_d = 1'b1;
		end
		if (!powered_d) begin
			wake_cnt_d  = 8'h00;
			wake_done_d = 1'b0;
		end else if (!wake_done_q) begin
			if (wake_cnt_q >= 8'(`WAKE_CYCLES - 1)) begin
				wake_done_d = 1'b1;
			end else begin
				wake_cnt_d = wake_cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			powered_q   <= 1'b0;
			wake_cnt_q  <= 8'h00;
			wake_done_q <= 1'b0;
			in_frame_q  <= 1'b0;
		end else begin
			powered_q   <= powered_d;
			wake_cnt_q  <= wake_cnt_d;
			wake_done_q <= wake_done_d;
			in_frame_q  <= in_frame_d;
		end
	end

	// register read, answered one cycle after the strobe
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	always_comb begin
		rdata_d = 16'h0000;
		if (reg_rd) begin
			unique case (reg_addr)
				`CTRL_OFFSET: begin
					rdata_d = {4'h0, ctrl_q};
				end
				`STATUS_OFFSET: begin
					rdata_d[`STAT_CONV_LSB +: 4]  = conv_chan_q;
					rdata_d[`STAT_NEXT_LSB +: 4]  = next_chan_q;
					rdata_d[`STAT_STATE_LSB +: 2] = state_q;
					rdata_d[`STAT_POWER_BIT]      = powered_q;
					rdata_d[`STAT_WAKE_BIT]       = wake_done_q;
					rdata_d[0]                    = cs_level;
				end
				default: begin
					rdata_d = 16'h0000; // shadow is write-only
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// outputs
	assign reg_rdata        = rdata_q;
	assign conv_start       = start_q;
	assign conv_sel         = sel_q;
	assign conv_fmt         = fmt_q;
	assign powered          = powered_q;
	assign wake_done        = wake_done_q;
	assign idle_output_hold = ctrl_q.idle_output_hold_bit;
	assign seq_state        = state_q;

endmodule // adc_channel_sequencer

`default_nettype wire

// file: tb/adc_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// timing and mode checks on the sequencer ports
module adc_seq_assertions
	import adc_seq_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// register port
	input wire logic [1:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	// frame pin and conversion control
	input wire logic        chip_select_low,
	input wire logic        conv_start,
	input wire input_sel_t  conv_sel,
	input wire result_fmt_t conv_fmt,
	input wire logic        powered,
	input wire logic        wake_done,
	input wire seq_state_t  seq_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic       ctl_w;
	logic [1:0] mode;
	// control write and its step and shadow bits
	assign ctl_w = reg_wr && reg_addr == 2'h0;
	assign mode  = {reg_wdata[11], reg_wdata[4]};

	frame_starts_a: assert property ($fell(chip_select_low) |-> ##[2:4] conv_start)
		else $error("frame without conversion");
	start_cause_a: assert property (conv_start |-> !$past(chip_select_low, 2))
		else $error("conversion without frame");
	se_pair_a: assert property (conv_start && !conv_sel.differential |->
		conv_sel.neg_input == conv_sel.pos_input) else $error("single input wrong");
	diff_pair_a: assert property (conv_start && conv_sel.differential |->
		conv_sel.neg_input == (conv_sel.pos_input ^ 4'h1)) else $error("pair wrong");
	coding_form_a: assert property (conv_start |->
		conv_fmt.twos_complement == !conv_fmt.coding_bit) else $error("coding wrong");
	mode_match_a: assert property (conv_start |->
		conv_sel.differential == !conv_fmt.single_ended_select) else $error("mode wrong");
	count_mode_a: assert property (ctl_w && mode == 2'b11 |=> seq_state == SEQ_COUNT)
		else $error("counter not entered");
	end_seq_a: assert property (ctl_w && mode == 2'b00 |=> seq_state == SEQ_DIRECT)
		else $error("sequence not ended");
	arm_mode_a: assert property (ctl_w && mode == 2'b01 |=> seq_state == SEQ_ARMED)
		else $error("shadow not armed");
	keep_seq_a: assert property (ctl_w && mode == 2'b10 |=> $stable(seq_state))
		else $error("sequence disturbed");
	full_power_a: assert property (ctl_w && reg_wdata[6] |-> ##[1:2] powered)
		else $error("not powered");
	wake_wait_a: assert property ($rose(powered) |-> !wake_done [*8])
		else $error("wake too early");
endmodule // adc_seq_assertions

bind adc_channel_sequencer adc_seq_assertions adc_seq_assertions_inst (.clk, .sys_rst,
	.reg_addr, .reg_wdata, .reg_wr, .chip_select_low, .conv_start, .conv_sel, .conv_fmt,
	.powered, .wake_done, .seq_state);

`default_nettype wire

// file: tb/frame_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"

// host side: one frame per request
module frame_host (
	// clock
	input  wire logic clk,
	// request and frame length
	input  wire logic go,
	input  wire logic slow,
	// frame pin and rest flag
	output logic      chip_select_low,
	output logic      idle
);
	int   cnt = 0;
	int   gap = 0;
	logic cs_q = 1'b1;
	// pin rests high, one driver only
	assign chip_select_low = cs_q;
	assign idle = (cnt == 0) && (gap == 0);
	// low for a frame, then rest the wake-up time
	always @(posedge clk) begin
		if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				cs_q <= 1'b1;
				gap <= `WAKE_CYCLES;
			end
		end else if (gap > 0)
			gap <= gap - 1;
		else if (go) begin
			cs_q <= 1'b0;
			cnt <= slow ? 14 : 6;
		end
	end
endmodule // frame_host

`default_nettype wire

// file: tb/adc_channel_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t %h %h", $time, (a), (b)); end end

module adc_channel_sequencer_tb
	import adc_seq_pkg::*;
;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [1:0]  reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        go = 1'b0;
	logic        slow = 1'b0;
	logic        idle;
	logic        chip_select_low;
	logic        conv_start;
	input_sel_t  conv_sel;
	result_fmt_t conv_fmt;
	logic        powered;
	logic        wake_done;
	logic        idle_output_hold;
	seq_state_t  seq_state;
	int          error_cnt = 0;
	int          tests_run = 0;

	// 10 MHz clock
	initial forever #50 clk = ~clk;

	adc_channel_sequencer adc_channel_sequencer_inst (.clk, .sys_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .chip_select_low, .conv_start, .conv_sel, .conv_fmt,
		.powered, .wake_done, .idle_output_hold, .seq_state);
	frame_host frame_host_inst (.clk, .go, .slow, .chip_select_low, .idle);

	// one write cycle, settled at the following low phase
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		@(negedge clk);
	endtask

	// control word from its fields
	task automatic wc(input logic s, input logic [3:0] a, input logic [1:0] pm,
		input logic sh, input logic [3:0] lo);
		wr(`CTRL_OFFSET, {4'h0, s, a, pm, sh, lo});
	endtask

	// one read cycle, data taken in the cycle after
	task automatic rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	// one frame, then the converted input pair
	task automatic frame(input logic [3:0] ch, input logic se);
		input_sel_t e;
		e = '{ch, se ? ch : ch ^ 4'h1, !se};
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (60) begin
			@(negedge clk);
			if (idle)
				break;
		end
		`CHK(conv_sel, e)
	endtask

	// every address in both input modes
	task automatic t_direct();
		for (int k = 0; k < 32; k++) begin
			wc(1'b0, k[3:0], 2'h3, 1'b0, {k[2], k[0], k[1], k[4]});
			frame(k[3:0], k[4]);
			`CHK(conv_fmt, {k[0], k[4], k[1], !k[1]})
			`CHK({powered, wake_done, idle_output_hold}, {2'b11, k[2]})
		end
	endtask

	// marked channels, a step-only write, then exit
	task automatic t_marks();
		wc(1'b0, 4'h0, 2'h3, 1'b1, 4'h1);
		wr(`SHADOW_OFFSET, 16'h2480);
		`CHK(seq_state, SEQ_MARKED)
		for (int i = 0; i < 5; i++)
			frame(4'(3 * (i % 3) + 2), 1'b1);
		wc(1'b1, 4'hF, 2'h3, 1'b0, 4'h3);
		`CHK(seq_state, SEQ_MARKED)
		frame(4'h8, 1'b1);
		`CHK(conv_fmt.twos_complement, 1'b0)
		wc(1'b0, 4'h6, 2'h3, 1'b0, 4'h1);
		frame(4'h6, 1'b1);
	endtask

	// empty mark set
	task automatic t_empty();
		wc(1'b0, 4'h0, 2'h3, 1'b1, 4'h1);
		wr(`SHADOW_OFFSET, 16'h0000);
		frame(4'hF, 1'b1);
		frame(4'hF, 1'b1);
	endtask

	// counter wraps after the last channel, slow frames
	task automatic t_count();
		slow = 1'b1;
		wc(1'b1, 4'h2, 2'h3, 1'b1, 4'h1);
		`CHK(seq_state, SEQ_COUNT)
		for (int i = 0; i < 5; i++)
			frame(4'(i % 3), 1'b1);
		slow = 1'b0;
	endtask

	// auto shutdown, status and the unmapped index
	task automatic t_power();
		logic [15:0] d;
		wc(1'b0, 4'h3, 2'h0, 1'b0, 4'h1);
		`CHK(seq_state, SEQ_DIRECT)
		rd(`CTRL_OFFSET, d);
		`CHK(d, 16'h0181)
		rd(`SHADOW_OFFSET, d);
		`CHK(d, 16'h0000)
		frame(4'h3, 1'b1);
		`CHK(powered, 1'b0)
		rd(`STATUS_OFFSET, d);
		`CHK(d, 16'h3301)
		wr(2'h3, 16'hFFFF);
		rd(2'h3, d);
		`CHK(d, 16'h0000)
		frame(4'h3, 1'b1);
	endtask

	// verdict and end of run
	task automatic final_report();
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_direct();
		t_marks();
		t_empty();
		t_count();
		t_power();
		final_report();
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report();
	end
endmodule // adc_channel_sequencer_tb

`default_nettype wire
